// [plhwc_pkg.sv]
package plhwc_pkg;

    // AXI4-Lite register byte offsets.
    localparam logic [7:0] OFS_GEN = 8'h00;
    localparam logic [7:0] OFS_MUX = 8'h04;
    localparam logic [7:0] OFS_OCLK = 8'h08;
    localparam logic [7:0] OFS_HOLD = 8'h0C;
    localparam logic [7:0] OFS_STAT = 8'h10;

    // Host port register select codes.
    localparam logic [3:0] SEL_HOLD = 4'h1;
    localparam logic [3:0] SEL_GEN = 4'h8;
    localparam logic [3:0] SEL_OCLK = 4'hA;
    localparam logic [3:0] SEL_MUX = 4'hB;

    // Field positions.
    localparam int GEN_SPLIT_BIT = 2;
    localparam int GEN_NIB_BIT = 3;
    localparam int OCLK_SCLK_LSB = 0;
    localparam int OCLK_VIDEO_CLOCK_OUT_LSB = 3;
    localparam int STAT_NIB_BIT = 0;
    localparam int STAT_BLANK_BIT = 1;
    localparam int STAT_BUSY_BIT = 2;

    // Reset values.
    localparam logic [7:0] RST_GEN = 8'h00;
    localparam logic [7:0] RST_MUX = 8'h00;
    localparam logic [7:0] RST_OCLK = 8'h00;
    localparam logic [7:0] RST_HOLD = 8'h00;

    // Mux control value that selects the pass-through bus.
    localparam logic [7:0] MUX_PASS = 8'h2D;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Flag pin function, coded as {bit 3, bit 2} of general control.
    typedef enum logic [1:0] {
        PLHWC_MODE_OFF = 2'b00,
        PLHWC_MODE_SPLIT = 2'b01,
        PLHWC_MODE_NIBBLE = 2'b10,
        PLHWC_MODE_BAD = 2'b11
    } plhwc_mode_type;

endpackage

// [plhwc_host_port.sv]
`timescale 1ns/1ps
// Brings the asynchronous host write port into the aclk domain.
module plhwc_host_port (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic host_write_strobe_n,
    input wire logic [3:0] host_reg_select,
    input wire logic [7:0] host_data,
    input wire logic dac_width_select,
    output logic wr_pulse,
    output logic [3:0] wr_addr,
    output logic [7:0] wr_data,
    output logic width_8bit
);

    // Two-stage synchronisers; stage one feeds only stage two.
    logic strobe_m_r, strobe_s_r, strobe_d_r;
    logic [3:0] addr_m_r, addr_s_r;
    logic [7:0] data_m_r, data_s_r;
    logic width_m_r, width_s_r;

    // Synchronise all host pins; the strobe idles high.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strobe_m_r <= 1'b1;
            strobe_s_r <= 1'b1;
            strobe_d_r <= 1'b1;
            addr_m_r <= 4'h0;
            addr_s_r <= 4'h0;
            data_m_r <= 8'h00;
            data_s_r <= 8'h00;
            width_m_r <= 1'b1;
            width_s_r <= 1'b1;
        end else begin
            strobe_m_r <= host_write_strobe_n;
            strobe_s_r <= strobe_m_r;
            strobe_d_r <= strobe_s_r;
            addr_m_r <= host_reg_select;
            addr_s_r <= addr_m_r;
            data_m_r <= host_data;
            data_s_r <= data_m_r;
            width_m_r <= dac_width_select;
            width_s_r <= width_m_r;
        end
    end

    // The write lands on the strobe's rising edge, so the host must hold
    // address and data a few aclk cycles past that edge.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_pulse <= 1'b0;
            wr_addr <= 4'h0;
            wr_data <= 8'h00;
            width_8bit <= 1'b1;
        end else begin
            wr_pulse <= strobe_s_r & ~strobe_d_r;
            wr_addr <= addr_s_r;
            wr_data <= data_s_r;
            width_8bit <= width_s_r;
        end
    end

endmodule // plhwc_host_port

// [plhwc_top.sv]
`timescale 1ns/1ps
// Overview of operation
// - Split mode: flag rise in blank gives extra shift clock.
// - Nibble mode samples flag at video clock fall.
// - Sampled flag picks high or low nibble.
// - Mode zero ignores the flag pin.
// - Host write lands on strobe rising edge.
// - Width high uses all eight data bits.
// - Width low shifts palette up two, zero fill.
// - Width low holding read zeroes two MSBs.
// - Pass-through bus supplies one byte per pixel.
// - Programmable video clock output is provided.
// - Shift clock stops during blanking except extra.
// - Mux value 2Dh selects pass-through mode.
module plhwc_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic host_write_strobe_n,
    input wire logic [3:0] host_reg_select,
    input wire logic [7:0] host_data,
    input wire logic dac_width_select,
    input wire logic dot_clk,
    input wire logic blank_n,
    input wire logic transfer_or_nibble_flag,
    input wire logic [31:0] pixel_bus,
    input wire logic [7:0] passthrough_pixel_bus,
    output logic shift_clock_out,
    output logic video_clock_out,
    output logic [31:0] pixel_out,
    output logic [7:0] dac_data_out
);

    logic hp_wr, hp_width;
    logic [3:0] hp_addr;
    logic [7:0] hp_data;
    logic [7:0] gen_ctrl_r, mux_ctrl_r, oclk_sel_r, hold_r; // Software settings.
    logic aw_got_r, w_got_r; // Address and data taken, in either order.
    logic [7:0] awaddr_r, wdata_r;
    logic wstrb0_r;
    logic cfg_req_r, cfg_ack_m_r, cfg_ack_s_r; // Settings handshake, aclk side.
    logic [8:0] cfg_bus_r, cfg_live; // {pass, video_clock_out half, sclk half, mode}.
    logic stat_nib_m_r, stat_nib_s_r, stat_blk_m_r, stat_blk_s_r;
    logic [7:0] hold_shift;
    // Dot clock domain state, declared here because the aclk side reads some of it.
    logic rst_m_r, dot_rst_n; // Reset release brought onto dot_clk.
    logic req_m_r, req_s_r, cfg_ack_r;
    logic blank_m_r, blank_s_r, flag_m_r, flag_s_r, flag_d_r;
    plhwc_pkg::plhwc_mode_type mode_r;
    logic pass_r;
    logic [2:0] sclk_half_r, video_clock_out_half_r, sclk_cnt_r, video_clock_out_cnt_r;
    logic sclk_ph_r, extra_pend_r, extra_act_r, nib_pend_r;
    logic split_en, nib_en, flag_rise, sclk_tick, video_clock_out_tick, video_clock_out_fall, sclk_gate, sclk_rise;
    logic [31:0] nib_word;

    // Host pins enter the aclk domain here.
    plhwc_host_port plhwc_host_port_i (
        .aclk(aclk),
        .aresetn(aresetn),
        .host_write_strobe_n(host_write_strobe_n),
        .host_reg_select(host_reg_select),
        .host_data(host_data),
        .dac_width_select(dac_width_select),
        .wr_pulse(hp_wr),
        .wr_addr(hp_addr),
        .wr_data(hp_data),
        .width_8bit(hp_width)
    );

    // AXI write channels: each side is taken alone, the response follows both.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= plhwc_pkg::RESP_OKAY;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 8'h00;
            wstrb0_r <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                s_axi_awready <= 1'b0;
                awaddr_r <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                s_axi_wready <= 1'b0;
                wdata_r <= s_axi_wdata[7:0];
                wstrb0_r <= s_axi_wstrb[0];
            end
            if (aw_got_r && w_got_r && !s_axi_bvalid) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // Unmapped or read-only offsets answer with an error.
                if (awaddr_r == plhwc_pkg::OFS_GEN || awaddr_r == plhwc_pkg::OFS_MUX ||
                    awaddr_r == plhwc_pkg::OFS_OCLK || awaddr_r == plhwc_pkg::OFS_HOLD) begin
                    s_axi_bresp <= plhwc_pkg::RESP_OKAY;
                end else begin
                    s_axi_bresp <= plhwc_pkg::RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Settings registers; a host strobe write in the same cycle wins.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gen_ctrl_r <= plhwc_pkg::RST_GEN;
            mux_ctrl_r <= plhwc_pkg::RST_MUX;
            oclk_sel_r <= plhwc_pkg::RST_OCLK;
            hold_r <= plhwc_pkg::RST_HOLD;
        end else begin
            if (aw_got_r && w_got_r && !s_axi_bvalid && wstrb0_r) begin
                case (awaddr_r)
                    plhwc_pkg::OFS_GEN: gen_ctrl_r <= wdata_r;
                    plhwc_pkg::OFS_MUX: mux_ctrl_r <= wdata_r;
                    plhwc_pkg::OFS_OCLK: oclk_sel_r <= wdata_r;
                    plhwc_pkg::OFS_HOLD: hold_r <= wdata_r;
                    default: ;
                endcase
            end
            if (hp_wr) begin
                case (hp_addr)
                    plhwc_pkg::SEL_GEN: gen_ctrl_r <= hp_data;
                    plhwc_pkg::SEL_MUX: mux_ctrl_r <= hp_data;
                    plhwc_pkg::SEL_OCLK: oclk_sel_r <= hp_data;
                    plhwc_pkg::SEL_HOLD: hold_r <= hp_data;
                    default: ;
                endcase
            end
        end
    end

    // AXI read channel with one beat in flight.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= plhwc_pkg::RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= plhwc_pkg::RESP_OKAY;
                s_axi_rdata <= 32'h0000_0000;
                case ({s_axi_araddr[7:2], 2'b00})
                    plhwc_pkg::OFS_GEN: s_axi_rdata[7:0] <= gen_ctrl_r;
                    plhwc_pkg::OFS_MUX: s_axi_rdata[7:0] <= mux_ctrl_r;
                    plhwc_pkg::OFS_OCLK: s_axi_rdata[7:0] <= oclk_sel_r;
                    plhwc_pkg::OFS_HOLD: s_axi_rdata[7:0] <= hp_width ? hold_r :
                                                             {2'b00, hold_r[5:0]};
                    plhwc_pkg::OFS_STAT: begin
                        s_axi_rdata[plhwc_pkg::STAT_NIB_BIT] <= stat_nib_s_r;
                        s_axi_rdata[plhwc_pkg::STAT_BLANK_BIT] <= stat_blk_s_r;
                        s_axi_rdata[plhwc_pkg::STAT_BUSY_BIT] <= cfg_req_r ^ cfg_ack_s_r;
                    end
                    default: s_axi_rresp <= plhwc_pkg::RESP_SLVERR;
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    assign hold_shift = {hold_r[5:0], 2'b00};

    // Output multiplexer toward the converter; the stored byte stays whole.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dac_data_out <= 8'h00;
        end else begin
            dac_data_out <= hp_width ? hold_r : hold_shift;
        end
    end

    assign cfg_live = {(mux_ctrl_r == plhwc_pkg::MUX_PASS),
                       oclk_sel_r[plhwc_pkg::OCLK_VIDEO_CLOCK_OUT_LSB +: 3],
                       oclk_sel_r[plhwc_pkg::OCLK_SCLK_LSB +: 3],
                       gen_ctrl_r[plhwc_pkg::GEN_NIB_BIT], gen_ctrl_r[plhwc_pkg::GEN_SPLIT_BIT]};

    // Settings are frozen in cfg_bus_r while a toggle handshake is open, so
    // the dot domain never sees a word in mid-change; cost is a few cycles.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_req_r <= 1'b0;
            cfg_bus_r <= 9'h000;
            cfg_ack_m_r <= 1'b0;
            cfg_ack_s_r <= 1'b0;
            stat_nib_m_r <= 1'b0;
            stat_nib_s_r <= 1'b0;
            stat_blk_m_r <= 1'b0;
            stat_blk_s_r <= 1'b0;
        end else begin
            cfg_ack_m_r <= cfg_ack_r;
            cfg_ack_s_r <= cfg_ack_m_r;
            stat_nib_m_r <= nib_pend_r;
            stat_nib_s_r <= stat_nib_m_r;
            stat_blk_m_r <= blank_s_r;
            stat_blk_s_r <= stat_blk_m_r;
            if ((cfg_req_r == cfg_ack_s_r) && (cfg_live != cfg_bus_r)) begin
                cfg_bus_r <= cfg_live;
                cfg_req_r <= ~cfg_req_r;
            end
        end
    end

    // Logic from here on runs on dot_clk; the host, DAC and holding-read checks at the end use aclk.

    // Reset and pin synchronisers for the dot domain.
    always_ff @(posedge dot_clk) begin
        rst_m_r <= aresetn;
        dot_rst_n <= rst_m_r;
        req_m_r <= cfg_req_r;
        req_s_r <= req_m_r;
        blank_m_r <= ~blank_n;
        blank_s_r <= blank_m_r;
        flag_m_r <= transfer_or_nibble_flag;
        flag_s_r <= flag_m_r;
        flag_d_r <= flag_s_r;
    end

    always_ff @(posedge dot_clk) begin
        if (!dot_rst_n) begin
            cfg_ack_r <= 1'b0;
            mode_r <= plhwc_pkg::PLHWC_MODE_OFF;
            pass_r <= 1'b0;
            sclk_half_r <= 3'h0;
            video_clock_out_half_r <= 3'h0;
        end else if (req_s_r != cfg_ack_r) begin
            cfg_ack_r <= req_s_r;
            mode_r <= plhwc_pkg::plhwc_mode_type'(cfg_bus_r[1:0]);
            sclk_half_r <= cfg_bus_r[4:2];
            video_clock_out_half_r <= cfg_bus_r[7:5];
            pass_r <= cfg_bus_r[8];
        end
    end

    // Decode of the flag pin's function; the forbidden code acts as off.
    always_comb begin
        split_en = 1'b0;
        nib_en = 1'b0;
        case (mode_r)
            plhwc_pkg::PLHWC_MODE_SPLIT: split_en = 1'b1;
            plhwc_pkg::PLHWC_MODE_NIBBLE: nib_en = 1'b1;
            default: ;
        endcase
    end

    assign flag_rise = flag_s_r & ~flag_d_r;
    assign sclk_tick = (sclk_cnt_r == sclk_half_r);
    assign video_clock_out_tick = (video_clock_out_cnt_r == video_clock_out_half_r);
    assign video_clock_out_fall = video_clock_out_tick & video_clock_out;
    assign sclk_gate = sclk_ph_r & (~blank_s_r | extra_act_r);
    assign sclk_rise = sclk_gate & ~shift_clock_out;

    // Free-running shift phase divider with the split-transfer extra cycle.
    always_ff @(posedge dot_clk) begin
        if (!dot_rst_n) begin
            sclk_cnt_r <= 3'h0;
            sclk_ph_r <= 1'b0;
            extra_pend_r <= 1'b0;
            extra_act_r <= 1'b0;
            shift_clock_out <= 1'b0;
        end else begin
            sclk_cnt_r <= sclk_tick ? 3'h0 : sclk_cnt_r + 3'h1;
            if (sclk_tick) begin
                sclk_ph_r <= ~sclk_ph_r;
            end
            // Request wins over its own consumption.
            extra_pend_r <= split_en & ((blank_s_r & flag_rise) |
                                        (extra_pend_r & ~(sclk_tick & ~sclk_ph_r)));
            if (sclk_tick && !sclk_ph_r && extra_pend_r) begin
                extra_act_r <= 1'b1;
            end else if (sclk_tick && sclk_ph_r) begin
                extra_act_r <= 1'b0;
            end
            shift_clock_out <= sclk_gate;
        end
    end

    always_ff @(posedge dot_clk) begin
        if (!dot_rst_n) begin
            video_clock_out_cnt_r <= 3'h0;
            video_clock_out <= 1'b0;
        end else begin
            video_clock_out_cnt_r <= video_clock_out_tick ? 3'h0 : video_clock_out_cnt_r + 3'h1;
            if (video_clock_out_tick) begin
                video_clock_out <= ~video_clock_out;
            end
        end
    end

    // Sample at video fall, hold till the next video fall.
    always_ff @(posedge dot_clk) begin
        if (!dot_rst_n) begin
            nib_pend_r <= 1'b0;
        end else if (nib_en && video_clock_out_fall) begin
            nib_pend_r <= flag_s_r;
        end
    end

    for (genvar b = 0; b < 4; b++) begin : g_nib
        assign nib_word[8*b +: 8] = {4'h0, nib_pend_r ? pixel_bus[8*b+4 +: 4] :
                                                        pixel_bus[8*b +: 4]};
    end

    // Pixel latch on each shift clock rise; pass-through outranks nibble mode.
    always_ff @(posedge dot_clk) begin
        if (!dot_rst_n) begin
            pixel_out <= 32'h0000_0000;
        end else if (sclk_rise) begin
            if (pass_r) begin
                pixel_out <= {24'h00_0000, passthrough_pixel_bus};
            end else if (nib_en) begin
                pixel_out <= nib_word;
            end else begin
                pixel_out <= pixel_bus;
            end
        end
    end

    extra_pulse_a: assert property (@(posedge dot_clk) disable iff (!dot_rst_n)
        (split_en && blank_s_r && flag_rise) |-> ##[1:40] sclk_rise)
        else $error("extra shift clock missing");
    blank_gate_a: assert property (@(posedge dot_clk) disable iff (!dot_rst_n)
        (blank_s_r && !extra_act_r) |=> !shift_clock_out)
        else $error("shift clock ran during blank");
    nib_sample_a: assert property (@(posedge dot_clk) disable iff (!dot_rst_n)
        (nib_en && video_clock_out_fall) |=> (nib_pend_r == $past(flag_s_r)))
        else $error("nibble flag not sampled");
    nib_hold_a: assert property (@(posedge dot_clk) disable iff (!dot_rst_n)
        !video_clock_out_fall |=> $stable(nib_pend_r))
        else $error("nibble select moved early");
    nib_latch_a: assert property (@(posedge dot_clk) disable iff (!dot_rst_n)
        (nib_en && !pass_r && sclk_rise) |=> (pixel_out == $past(nib_word)))
        else $error("wrong nibble latched");
    flag_ignore_a: assert property (@(posedge dot_clk) disable iff (!dot_rst_n)
        (mode_r == plhwc_pkg::PLHWC_MODE_OFF) |=> (!extra_pend_r && $stable(nib_pend_r)))
        else $error("flag acted while off");
    pass_mux_a: assert property (@(posedge dot_clk) disable iff (!dot_rst_n)
        (pass_r && sclk_rise) |=> (pixel_out == {24'h00_0000, $past(passthrough_pixel_bus)}))
        else $error("pass-through byte not taken");
    video_clock_out_run_a: assert property (@(posedge dot_clk) disable iff (!dot_rst_n)
        video_clock_out |-> ##[1:9] !video_clock_out)
        else $error("video clock stuck high");
    cfg_load_a: assert property (@(posedge dot_clk) disable iff (!dot_rst_n)
        $changed(mode_r) |-> $past(req_s_r != cfg_ack_r))
        else $error("settings changed outside handshake");
    host_cap_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (hp_wr && hp_addr == plhwc_pkg::SEL_GEN) |=> (gen_ctrl_r == $past(hp_data)))
        else $error("host strobe write lost");
    dac_six_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !hp_width |=> (dac_data_out == $past(hold_shift)))
        else $error("six-bit shift wrong");
    dac_eight_a: assert property (@(posedge aclk) disable iff (!aresetn)
        hp_width |=> (dac_data_out == $past(hold_r)))
        else $error("eight-bit feed wrong");
    hold_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && !hp_width &&
         {s_axi_araddr[7:2], 2'b00} == plhwc_pkg::OFS_HOLD) |=> (s_axi_rdata[7:6] == 2'b00))
        else $error("holding read MSBs not zero");

    extra_seen_c: cover property (@(posedge dot_clk) disable iff (!dot_rst_n)
        extra_act_r && sclk_rise);
    nib_seen_c: cover property (@(posedge dot_clk) disable iff (!dot_rst_n)
        nib_en && nib_pend_r && sclk_rise);
    pass_seen_c: cover property (@(posedge dot_clk) disable iff (!dot_rst_n)
        pass_r && sclk_rise);
    host_seen_c: cover property (@(posedge aclk) disable iff (!aresetn) hp_wr);

endmodule // plhwc_top

// [plhwc_gfx_model.sv]
`timescale 1ns/1ps
// Graphics-side partner that drives blanking, the flag pin and both pixel buses.
module plhwc_gfx_model (
    input wire logic dot_clk,
    input wire logic blank_req,
    input wire logic flag_req,
    input wire logic [31:0] pix_req,
    output logic blank_n = 1'b1,
    output logic transfer_or_nibble_flag = 1'b0,
    output logic [31:0] pixel_bus = 32'h0,
    output logic [7:0] passthrough_pixel_bus = 8'h0
);
    // Everything is launched on the dot clock, as the graphics processor would launch it.
    always @(posedge dot_clk) begin
        blank_n <= !blank_req;
        transfer_or_nibble_flag <= flag_req;
        pixel_bus <= pix_req;
        // The bypass byte differs from the main bus, so a wrong source is seen.
        passthrough_pixel_bus <= pix_req[7:0] ^ 8'h5A;
    end
endmodule // plhwc_gfx_model

// [pixel_latch_and_host_width_ctl_tb_top.sv]
`timescale 1ns/1ps
// Self-checking bench: AXI master, host strobe port and pixel-side probes.
module pixel_latch_and_host_width_ctl_tb_top;
    logic aclk = 0, dot_clk = 0, aresetn = 0, blank_n, blk = 0, flg = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, host_data = 0, passthrough_pixel_bus;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, pixel_bus, pixel_out, pix = 0;
    logic [3:0] s_axi_wstrb = 4'hF, host_reg_select = 0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, host_write_strobe_n = 1, dac_width_select = 1;
    logic transfer_or_nibble_flag, shift_clock_out, video_clock_out;
    logic [7:0] dac_data_out;
    int n_fail = 0, total_checks = 0, k, h, t;
    initial forever #2.5 aclk = ~aclk;
    // The dot clock is offset so its edges never line up with aclk.
    initial begin
        #1.3;
        forever #3 dot_clk = ~dot_clk;
    end
    plhwc_gfx_model plhwc_gfx_model_i (.dot_clk(dot_clk), .blank_req(blk), .flag_req(flg),
        .pix_req(pix), .blank_n(blank_n), .transfer_or_nibble_flag(transfer_or_nibble_flag),
        .pixel_bus(pixel_bus), .passthrough_pixel_bus(passthrough_pixel_bus));
    plhwc_top plhwc_top_i (.*);
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // A used-up wait bound is a failure and ends the run.
    task automatic tmo();
        if (k >= 200) begin
            n_fail++;
            give_verdict();
        end
    endtask
    // Every bus task starts and ends just after a rising aclk edge.
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        for (k = 0; k < 200 && (k == 0 || s_axi_bready); k++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 0;
                chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
            end
        end
        tmo();
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        for (k = 0; k < 200 && (k == 0 || s_axi_rready); k++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 0;
                chk("rdata", e, s_axi_rdata);
                chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
            end
        end
        tmo();
    endtask
    // Select and data are held well before and after the strobe rise.
    task automatic hw(input logic [3:0] s, input logic [7:0] d);
        host_reg_select <= s;
        host_data <= d;
        repeat (4) @(posedge aclk);
        host_write_strobe_n <= 0;
        repeat (4) @(posedge aclk);
        host_write_strobe_n <= 1;
        repeat (8) @(posedge aclk);
    endtask
    // Counts shift clock highs and video clock toggles over 40 dot cycles.
    task automatic cnt();
        logic v;
        h = 0;
        t = 0;
        v = video_clock_out;
        repeat (40) begin
            @(negedge dot_clk);
            h += int'(shift_clock_out);
            t += int'(video_clock_out != v);
            v = video_clock_out;
        end
        @(posedge aclk);
    endtask
    task automatic wpix(input logic [31:0] e);
        for (k = 0; k < 200 && pixel_out !== e; k++) @(posedge aclk);
        chk("pixel_out", e, pixel_out);
        tmo();
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        axr(8'h00, 32'h0, plhwc_pkg::RESP_OKAY);
        axr(8'h14, 32'h0, plhwc_pkg::RESP_SLVERR);
        axw(8'h10, 32'h1, plhwc_pkg::RESP_SLVERR);
        blk <= 1;
        repeat (20) @(posedge aclk);
        flg <= 1;
        cnt();
        chk("blank sclk", 32'd0, 32'(h));
        chk("video_clock_out toggles", 32'd40, 32'(t));
        axr(8'h10, 32'h2, plhwc_pkg::RESP_OKAY);
        flg <= 0;
        axw(8'h08, 32'h08, plhwc_pkg::RESP_OKAY);
        // Only the split code is used here; both mode bits are never set together.
        axw(8'h00, 32'h04, plhwc_pkg::RESP_OKAY);
        repeat (20) @(posedge aclk);
        flg <= 1;
        cnt();
        chk("extra sclk", 32'd1, 32'(h));
        chk("video_clock_out toggles", 32'd20, 32'(t));
        flg <= 0;
        blk <= 0;
        pix <= 32'hABCDEF12;
        axw(8'h00, 32'h08, plhwc_pkg::RESP_OKAY);
        flg <= 1;
        wpix(32'h0A0C0E01);
        axr(8'h10, 32'h1, plhwc_pkg::RESP_OKAY);
        flg <= 0;
        wpix(32'h0B0D0F02);
        axw(8'h04, 32'h2D, plhwc_pkg::RESP_OKAY);
        wpix(32'h48);
        // A write whose low byte lane is disabled must leave the mux setting alone.
        s_axi_wstrb <= 4'hE;
        axw(8'h04, 32'h00, plhwc_pkg::RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        axr(8'h04, 32'h2D, plhwc_pkg::RESP_OKAY);
        hw(4'h1, 8'hA7);
        chk("dac", 32'hA7, {24'h0, dac_data_out});
        axr(8'h0C, 32'hA7, plhwc_pkg::RESP_OKAY);
        dac_width_select <= 0;
        repeat (8) @(posedge aclk);
        chk("dac", 32'h9C, {24'h0, dac_data_out});
        axr(8'h0C, 32'h27, plhwc_pkg::RESP_OKAY);
        give_verdict();
    end
endmodule // pixel_latch_and_host_width_ctl_tb_top
